/* File: dv/aux_cmd_asserts.sv */
// Port checks for the auxiliary command handler.
`timescale 1ns/100ps
module aux_cmd_asserts
    import aux_cmd_pkg::*;
#(
    parameter int SELF_TEST_CYC = 30
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       link_clk,
    input wire logic       link_rd_req,
    input wire logic       link_rd_ack,
    input wire logic       link_rd_nack,
    input wire logic       cfg_write,
    input wire cfg_t       cfg_in,
    input wire logic       cal_event,
    input wire cal_t       cal_in,
    input wire cfg_t       cfg,
    input wire cfg_t       nv_cfg,
    input wire logic       nv_cfg_we,
    input wire cal_t       nv_cal,
    input wire logic       nv_cal_we,
    input wire logic       busy
);
    // ************************************************************
    // Helpers and properties
    // ************************************************************
    int busy_cnt;
    // Counts how long the present command has run.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy ? busy_cnt + 1 : 0;
        end
    end
    // A read request and its single answer form the read step.
    sequence s_rd_req;
        link_rd_req;
    endsequence
    sequence s_one_answer;
        link_rd_ack ^ link_rd_nack;
    endsequence
    property p_rd_answer;
        @(posedge link_clk) disable iff (!resetn) s_rd_req |=> s_one_answer;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered once");
    property p_no_stray;
        @(posedge link_clk) disable iff (!resetn) (link_rd_ack || link_rd_nack) |-> $past(link_rd_req);
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("answer without request");
    property p_cfg_load;
        @(posedge clk) disable iff (!resetn) cfg_write |=> cfg == $past(cfg_in);
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("config not loaded");
    property p_cfg_hold;
        @(posedge clk) disable iff (!resetn) !cfg_write |=> $stable(cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unasked");
    property p_cal_store;
        @(posedge clk) disable iff (!resetn) cal_event |=> nv_cal_we && nv_cal == $past(cal_in);
    endproperty
    a_cal_store: assert property (p_cal_store) else $error("history not stored");
    property p_cal_cause;
        @(posedge clk) disable iff (!resetn) nv_cal_we |-> $past(cal_event);
    endproperty
    a_cal_cause: assert property (p_cal_cause) else $error("history write without event");
    property p_nv_change;
        @(posedge clk) disable iff (!resetn) $changed(nv_cfg) |-> nv_cfg_we;
    endproperty
    a_nv_change: assert property (p_nv_change) else $error("saved copy changed unasked");
    property p_nv_copy;
        @(posedge clk) disable iff (!resetn) nv_cfg_we |-> nv_cfg == $past(cfg) ##1 !nv_cfg_we;
    endproperty
    a_nv_copy: assert property (p_nv_copy) else $error("saved copy wrong");
    property p_busy_bound;
        @(posedge clk) disable iff (!resetn) busy_cnt <= SELF_TEST_CYC + 2;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("command overran");
endmodule

bind sensor_aux_command_handler aux_cmd_asserts #(.SELF_TEST_CYC(SELF_TEST_CYC)) u_chk (
    .clk(clk), .resetn(resetn), .link_clk(link_clk), .link_rd_req(link_rd_req),
    .link_rd_ack(link_rd_ack), .link_rd_nack(link_rd_nack), .cfg_write(cfg_write), .cfg_in(cfg_in),
    .cal_event(cal_event), .cal_in(cal_in), .cfg(cfg), .nv_cfg(nv_cfg), .nv_cfg_we(nv_cfg_we),
    .nv_cal(nv_cal), .nv_cal_we(nv_cal_we), .busy(busy));

/* File: dv/aux_host_model.sv */
// Host controller model that drives the command link.
`timescale 1ns/100ps
module aux_host_model
    import aux_cmd_pkg::*;
(
    output logic            link_clk,
    output logic            link_start,
    output logic            link_wr_valid,
    output logic [7:0]      link_wr_data,
    output logic            link_rd_req,
    input  wire logic [7:0] link_rd_data,
    input  wire logic       link_rd_ack,
    input  wire logic       link_rd_nack
);
    logic       lk_en = 1'b0;
    logic [7:0] got [0:9];
    logic       ack [0:9];
    logic       nk [0:9];
    int         n_saves = 0;
    // The link clock runs only around frames.
    initial begin
        link_clk = 1'b0;
        link_start = 1'b0;
        link_wr_valid = 1'b0;
        link_wr_data = 8'h00;
        link_rd_req = 1'b0;
        #3;
        forever #6 link_clk = lk_en ? ~link_clk : 1'b0;
    end
    // Opens a frame, long enough for a finished response to cross, or closes it after a few trailing cycles.
    task automatic frame(input bit on);
        if (on) begin
            lk_en = 1'b1;
            repeat (6) @(posedge link_clk);
        end else begin
            repeat (4) @(posedge link_clk);
            lk_en = 1'b0;
        end
    endtask
    // Sends one code, high byte first; saves are counted against wear.
    task automatic send_cmd(input logic [15:0] code);
        frame(1);
        if (code == CMD_SAVE_CONFIG) n_saves++;
        link_start <= 1'b1;
        @(posedge link_clk);
        link_start <= 1'b0;
        link_wr_valid <= 1'b1;
        link_wr_data <= code[15:8];
        @(posedge link_clk);
        link_wr_data <= code[7:0];
        @(posedge link_clk);
        link_wr_valid <= 1'b0;
        link_wr_data <= ~code[7:0];
        frame(0);
    endtask
    // Reads n bytes back to back; each answer is sampled 1 ns after the link edge that takes its request.
    task automatic read_n(input int n);
        frame(1);
        for (int i = 0; i <= n; i++) begin
            @(posedge link_clk);
            #1;
            if (i > 0) begin
                got[i-1] = link_rd_data;
                ack[i-1] = link_rd_ack;
                nk[i-1] = link_rd_nack;
            end
            link_rd_req <= (i < n);
        end
        frame(0);
    endtask
endmodule

/* File: dv/sensor_aux_command_handler_tb_top.sv */
// Self-checking bench for the auxiliary command handler.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module sensor_aux_command_handler_tb_top;
    import aux_cmd_pkg::*;
    localparam logic [47:0] SER = 48'h5a5a_1234_c3c3; // Arbitrary value.
    localparam int QC = 5;
    localparam int SC = 20;
    localparam int TC = 30;
    logic clk, resetn, lclk, lstart, lvalid, lreq, lack, lnack, data_ready, cfg_write, cal_event, ffault, sfault;
    logic nv_cfg_we, nv_cal_we, busy, rdy;
    logic [7:0] ldata, rdata;
    cfg_t cfg_in, cfg, nv_cfg, cfg_r;
    cal_t cal_in, nv_cal, cal_r;
    int n_fail = 0;
    int total_checks = 0;
    sensor_aux_command_handler #(.QUERY_CYC(QC), .SAVE_CYC(SC), .SELF_TEST_CYC(TC), .SERIAL_ID(SER)) DUT (
        .clk(clk), .resetn(resetn), .link_clk(lclk), .link_start(lstart), .link_wr_valid(lvalid),
        .link_wr_data(ldata), .link_rd_req(lreq), .link_rd_data(rdata), .link_rd_ack(lack), .link_rd_nack(lnack),
        .data_ready(data_ready), .cfg_write(cfg_write), .cfg_in(cfg_in), .cal_event(cal_event), .cal_in(cal_in),
        .function_fault(ffault), .supply_fault(sfault), .cfg(cfg), .nv_cfg(nv_cfg), .nv_cfg_we(nv_cfg_we),
        .nv_cal(nv_cal), .nv_cal_we(nv_cal_we), .busy(busy));
    aux_host_model host (.link_clk(lclk), .link_start(lstart), .link_wr_valid(lvalid), .link_wr_data(ldata),
        .link_rd_req(lreq), .link_rd_data(rdata), .link_rd_ack(lack), .link_rd_nack(lnack));
    // ************************************************************
    // Expectations and tasks
    // ************************************************************
    function automatic logic [7:0] sum8(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 15; i >= 0; i--) c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h31) : (c << 1);
        return c;
    endfunction
    // Sends a command and waits its full duration before any read.
    task automatic run_cmd(input logic [15:0] code, input int dur);
        host.send_cmd(code);
        repeat (dur + 12) @(posedge clk);
    endtask
    // Reads nw words plus one extra byte and compares them.
    task automatic check_resp(input int nw, input logic [47:0] w);
        logic [23:0] e;
        host.read_n(3 * nw + 1);
        for (int k = 0; k < nw; k++) begin
            e = {w[47-16*k -: 16], sum8(w[47-16*k -: 16])};
            for (int b = 0; b < 3; b++) begin
                `CHK("rd_data", e[23-8*b -: 8], host.got[3*k+b])
                `CHK("rd_ack", 1'b1, host.ack[3*k+b])
            end
        end
        `CHK("nack_after_last", 1'b1, host.nk[3*nw])
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Core clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog against a hang.
    initial begin
        #100_000;
        n_fail++;
        complete_run();
    end
    // Main sequence.
    initial begin
        {resetn, data_ready, cfg_write, cal_event, ffault, sfault} = '0;
        cfg_in = '0;
        cal_in = '0;
        void'($urandom(32'hdb33_f08f));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        `CHK("cfg_reset", cfg_t'({16'h0000, 16'h0000, 1'b1}), cfg)
        `CHK("nv_cfg_reset", cfg_t'(33'h0), nv_cfg)
        host.read_n(1);
        `CHK("early_nack", 1'b1, host.nk[0])
        for (int i = 0; i < 4; i++) begin
            rdy = (i < 2) ? i[0] : 1'($urandom);
            data_ready <= rdy;
            run_cmd(CMD_DATA_READY, QC);
            check_resp(1, {rdy ? 16'h8001 : 16'h8000, 32'h0});
            ffault <= i[0];
            sfault <= i[1];
            run_cmd(CMD_SELF_TEST, TC);
            check_resp(1, {14'h0, i[1], i[0], 32'h0});
        end
        run_cmd(CMD_SERIAL, QC);
        check_resp(3, SER);
        cfg_r = {16'($urandom), 16'($urandom), 1'($urandom)};
        cal_r = {1'($urandom), 16'($urandom)};
        cfg_in <= cfg_r;
        cal_in <= cal_r;
        {cfg_write, cal_event} <= 2'b11;
        @(posedge clk);
        {cfg_write, cal_event} <= 2'b00;
        @(posedge clk);
        #1;
        `CHK("cfg", cfg_r, cfg)
        `CHK("nv_cal", cal_r, nv_cal)
        `CHK("nv_cfg_unsaved", cfg_t'(33'h0), nv_cfg)
        host.send_cmd(CMD_SAVE_CONFIG);
        for (int k = 0; k < SC + 40 && nv_cfg_we !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        `CHK("save_done", 1'b1, nv_cfg_we)
        `CHK("nv_cfg", cfg_r, nv_cfg)
        repeat (12) @(posedge clk);
        host.read_n(1);
        `CHK("save_no_data", 1'b1, host.nk[0])
        run_cmd(16'hffff, QC);
        host.read_n(1);
        `CHK("unknown_nack", 1'b1, host.nk[0])
        complete_run();
    end
endmodule

/* File: logic/aux_cmd_pkg.sv */
// Shared types, command codes and timing constants for the auxiliary command handler.
package aux_cmd_pkg;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [15:0] CMD_DATA_READY  = 16'he4b8;
    localparam logic [15:0] CMD_SAVE_CONFIG = 16'h3615;
    localparam logic [15:0] CMD_SERIAL      = 16'h3682;
    localparam logic [15:0] CMD_SELF_TEST   = 16'h3639;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ          = 100_000_000;
    localparam int CYC_PER_MS      = CLK_HZ / 1000;
    localparam int T_QUERY_MS      = 1;
    localparam int T_SAVE_MS       = 800;
    localparam int T_SELF_TEST_MS  = 10000;
    localparam int QUERY_CYCLES    = T_QUERY_MS * CYC_PER_MS;
    localparam int SAVE_CYCLES     = T_SAVE_MS * CYC_PER_MS;
    localparam int SELF_TEST_CYCLES = T_SELF_TEST_MS * CYC_PER_MS;

    // ************************************************************
    // Response layout and field values
    // ************************************************************
    localparam int          RESP_MAX_BYTES  = 9;
    localparam logic [3:0]  LEN_ONE_WORD    = 4'h3;
    localparam logic [3:0]  LEN_SERIAL      = 4'h9;
    localparam logic [15:0] READY_WORD_BASE = 16'h8000;
    localparam logic [15:0] READY_WORD_SET  = 16'h0001;
    localparam logic [7:0]  CRC_POLY        = 8'h31;
    localparam logic [7:0]  CRC_INIT        = 8'hff;
    localparam logic [15:0] CFG_OFFSET_RST  = 16'h0000;
    localparam logic [15:0] CFG_ALT_RST     = 16'h0000;
    localparam logic [47:0] SERIAL_DEFAULT  = 48'h0123_4567_89ab;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [15:0] temp_offset;
        logic [15:0] altitude;
        logic        auto_self_calibration;
    } cfg_t;

    typedef struct packed {
        logic        forced_recalibration;
        logic [15:0] value;
    } cal_t;

    typedef struct packed {
        logic [3:0]                      len;
        logic [RESP_MAX_BYTES*8-1:0]     bytes;
    } resp_t;

    // Checksum over one word, high byte first.
    function automatic logic [7:0] crc8_word(input logic [15:0] word);
        logic [7:0] crc;
        crc = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (crc[7] ^ word[i]) begin
                crc = {crc[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                crc = {crc[6:0], 1'b0};
            end
        end
        return crc;
    endfunction

endpackage

/* File: logic/sensor_aux_command_handler.sv */
// Auxiliary command handler: data-ready query, save configuration, serial number and self-test.
//
// Operation
// - Data-ready query answers one word plus checksum; low 11 bits nonzero when ready.
// - Configuration lives in volatile registers, lost at reset unless saved; the code clears nv_cfg at reset too and never reloads cfg from it.
// - Save command copies configuration to non-volatile store within 800 ms, no reply.
// - Calibration history is stored automatically in its own non-volatile store.
// - Serial command answers three words, each followed by its checksum, within 1 ms.
// - Serial number is big-endian: first word bits 47..32, last word 15..0.
// - Self-test checks function and supply, answers zero for no fault, nonzero else.
// - A read with no response available is answered with a NACK.
`timescale 1ns/100ps
module sensor_aux_command_handler
    import aux_cmd_pkg::*;
#(
    parameter int          QUERY_CYC     = QUERY_CYCLES,
    parameter int          SAVE_CYC      = SAVE_CYCLES,
    parameter int          SELF_TEST_CYC = SELF_TEST_CYCLES,
    parameter logic [47:0] SERIAL_ID     = SERIAL_DEFAULT   // Arbitrary value.
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        link_clk,
    input  wire logic        link_start,
    input  wire logic        link_wr_valid,
    input  wire logic [7:0]  link_wr_data,
    input  wire logic        link_rd_req,
    output logic [7:0]       link_rd_data,
    output logic             link_rd_ack,
    output logic             link_rd_nack,
    input  wire logic        data_ready,
    input  wire logic        cfg_write,
    input  wire cfg_t        cfg_in,
    input  wire logic        cal_event,
    input  wire cal_t        cal_in,
    input  wire logic        function_fault,
    input  wire logic        supply_fault,
    output cfg_t             cfg,
    output cfg_t             nv_cfg,
    output logic             nv_cfg_we,
    output cal_t             nv_cal,
    output logic             nv_cal_we,
    output logic             busy
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (QUERY_CYC < 1 || QUERY_CYC > QUERY_CYCLES) begin : g_bad_query
        $error("Query duration out of range.");
    end
    if (SAVE_CYC < 1 || SAVE_CYC > SAVE_CYCLES) begin : g_bad_save
        $error("Save duration out of range.");
    end
    if (SELF_TEST_CYC < 1 || SELF_TEST_CYC > SELF_TEST_CYCLES) begin : g_bad_test
        $error("Self-test duration out of range.");
    end

    // ************************************************************
    // Link domain: command assembly
    // ************************************************************
    logic        hi_seen;
    logic [7:0]  cmd_hi;
    logic [15:0] cmd_word;
    logic        cmd_tgl;
    logic        resp_tgl;
    logic        resp_tgl_link;
    logic        resp_seen;
    logic        resp_avail;
    logic [3:0]  rd_idx;
    resp_t       resp;

    wire logic   cmd_done = link_wr_valid && hi_seen;
    wire logic   resp_new = resp_tgl_link != resp_seen;
    wire logic   rd_ok    = resp_avail && (rd_idx < resp.len);
    // A byte is delivered only when the response is not being replaced in the same cycle.
    wire logic   rd_go    = link_rd_req && rd_ok && !cmd_done && !resp_new;

    // Two bytes form a command, high byte first; the word stays put until the next one.
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            hi_seen  <= 1'b0;
            cmd_hi   <= 8'h00;
            cmd_word <= 16'h0000;
            cmd_tgl  <= 1'b0;
        end else if (link_start) begin
            hi_seen <= 1'b0;
        end else if (link_wr_valid) begin
            hi_seen <= !hi_seen;
            cmd_hi  <= link_wr_data;
            if (cmd_done) begin
                cmd_word <= {cmd_hi, link_wr_data};
                cmd_tgl  <= !cmd_tgl;
            end
        end
    end

    // ************************************************************
    // Link domain: response read-out
    // ************************************************************
    toggle_sync u_resp_sync (
        .clk    (link_clk),
        .resetn (resetn),
        .din    (resp_tgl),
        .dout   (resp_tgl_link)
    );

    // A fresh command discards the old response; reads past the end or before one is ready get a NACK.
    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) begin
            resp_seen    <= 1'b0;
            resp_avail   <= 1'b0;
            rd_idx       <= 4'h0;
            link_rd_data <= 8'h00;
            link_rd_ack  <= 1'b0;
            link_rd_nack <= 1'b0;
        end else begin
            link_rd_ack  <= rd_go;
            link_rd_nack <= link_rd_req && !rd_go;
            if (cmd_done) begin
                resp_seen  <= resp_tgl_link;
                resp_avail <= 1'b0;
            end else if (resp_new) begin
                resp_seen  <= resp_tgl_link;
                resp_avail <= resp.len != 4'h0;
                rd_idx     <= 4'h0;
            end else if (rd_go) begin
                link_rd_data <= resp.bytes[(RESP_MAX_BYTES - 1 - 32'(rd_idx)) * 8 +: 8];
                rd_idx       <= rd_idx + 4'h1;
            end
        end
    end

    // ************************************************************
    // Core domain: command execution
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_RUN} state_t;

    state_t      state;
    logic        cmd_tgl_core;
    logic        cmd_seen;
    logic [15:0] active_cmd;
    logic [31:0] count;

    wire logic   cmd_new   = cmd_tgl_core != cmd_seen;
    wire logic   run_done  = (state == ST_RUN) && (count == 32'd1);
    wire logic   known_cmd = cmd_word == CMD_DATA_READY || cmd_word == CMD_SAVE_CONFIG
                             || cmd_word == CMD_SERIAL || cmd_word == CMD_SELF_TEST;
    wire logic [31:0] run_len = (cmd_word == CMD_SAVE_CONFIG) ? 32'(SAVE_CYC)
                              : (cmd_word == CMD_SELF_TEST)   ? 32'(SELF_TEST_CYC)
                              : 32'(QUERY_CYC);
    wire logic [15:0] ready_word = data_ready ? (READY_WORD_BASE | READY_WORD_SET)
                                              : READY_WORD_BASE;
    wire logic [15:0] test_word  = {14'h0000, supply_fault, function_fault};
    wire logic [15:0] ser_w0 = SERIAL_ID[47:32];
    wire logic [15:0] ser_w1 = SERIAL_ID[31:16];
    wire logic [15:0] ser_w2 = SERIAL_ID[15:0];

    toggle_sync u_cmd_sync (
        .clk    (clk),
        .resetn (resetn),
        .din    (cmd_tgl),
        .dout   (cmd_tgl_core)
    );

    // A recognised command runs for its duration; commands arriving while busy are dropped.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state      <= ST_IDLE;
            cmd_seen   <= 1'b0;
            active_cmd <= 16'h0000;
            count      <= 32'd0;
            busy       <= 1'b0;
        end else begin
            if (cmd_new) begin
                cmd_seen <= cmd_tgl_core;
            end
            unique case (state)
                ST_IDLE: begin
                    if (cmd_new && known_cmd) begin
                        active_cmd <= cmd_word;
                        count      <= run_len;
                        state      <= ST_RUN;
                        busy       <= 1'b1;
                    end
                end
                ST_RUN: begin
                    count <= count - 32'd1;
                    if (run_done) begin
                        state <= ST_IDLE;
                        busy  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // The response is built at completion and is stable while the link reads it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resp     <= '0;
            resp_tgl <= 1'b0;
        end else if (run_done) begin
            resp_tgl <= !resp_tgl;
            resp     <= '0;
            unique case (active_cmd)
                CMD_DATA_READY: begin
                    resp.len   <= LEN_ONE_WORD;
                    resp.bytes[71:48] <= {ready_word, crc8_word(ready_word)};
                end
                CMD_SERIAL: begin
                    resp.len   <= LEN_SERIAL;
                    resp.bytes <= {ser_w0, crc8_word(ser_w0), ser_w1, crc8_word(ser_w1),
                                   ser_w2, crc8_word(ser_w2)};
                end
                CMD_SELF_TEST: begin
                    resp.len   <= LEN_ONE_WORD;
                    resp.bytes[71:48] <= {test_word, crc8_word(test_word)};
                end
                default: begin
                    resp.len <= 4'h0;
                end
            endcase
        end
    end

    // ************************************************************
    // Configuration and non-volatile stores
    // ************************************************************
    // Working configuration is volatile; only a save command copies it to the store.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg <= '{temp_offset: CFG_OFFSET_RST, altitude: CFG_ALT_RST,
                     auto_self_calibration: 1'b1};
            nv_cfg    <= '0;
            nv_cfg_we <= 1'b0;
            nv_cal    <= '0;
            nv_cal_we <= 1'b0;
        end else begin
            if (cfg_write) begin
                cfg <= cfg_in;
            end
            nv_cfg_we <= run_done && active_cmd == CMD_SAVE_CONFIG;
            if (run_done && active_cmd == CMD_SAVE_CONFIG) begin
                nv_cfg <= cfg;
            end
            nv_cal_we <= cal_event;
            if (cal_event) begin
                nv_cal <= cal_in;
            end
        end
    end

endmodule

/* File: logic/toggle_sync.sv */
// Three-stage synchroniser that accepts a new level once the last two stages agree.
`timescale 1ns/100ps
module toggle_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      dout
);
    logic s1;
    logic s2;
    logic s3;

    // Shift the level in; the first stage feeds only the second.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule
